// [ccdiv_out_model.sv]
// ccdiv_out_model: output driver model measuring channel clock high and low run lengths
`timescale 1ns/100ps
`default_nettype none
module ccdiv_out_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_in,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len
);
  // ==========================================
  // run-length capture, one sample per reference cycle
  logic last;
  logic [15:0] run;
  always @(posedge clk) begin
    if (rst) begin
      last <= 1'b0;
      run <= 16'h0000;
      hi_len <= 16'h0000;
      lo_len <= 16'h0000;
    end else if (clk_in === last) begin
      run <= run + 16'h0001;
    end else begin
      if (last) hi_len <= run;
      else lo_len <= run;
      last <= clk_in;
      run <= 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [ccdiv_pkg.sv]
// ccdiv_pkg: register map, field layout and carrier types of the channel divider
package ccdiv_pkg;
  // ==========================================
  // register indices (byte address = 4 * index)
  localparam logic [9:0] IDX_S1_COUNTS = 10'h199;
  localparam logic [9:0] IDX_PHASE = 10'h19a;
  localparam logic [9:0] IDX_S2_COUNTS = 10'h19b;
  localparam logic [9:0] IDX_CONTROL = 10'h19c;
  localparam logic [9:0] IDX_DUTY = 10'h19d;
  localparam logic [9:0] IDX_D3_COUNTS = 10'h19e;
  localparam logic [9:0] IDX_STATUS = 10'h1af;
  // ==========================================
  // field positions
  localparam int LOW_LSB = 4;
  localparam int HIGH_LSB = 0;
  localparam int PH_S2_LSB = 4;
  localparam int PH_S1_LSB = 0;
  localparam int BIT_BYP_S2 = 5;
  localparam int BIT_BYP_S1 = 4;
  localparam int BIT_NOSYNC = 3;
  localparam int BIT_FORCE = 2;
  localparam int BIT_START_S2 = 1;
  localparam int BIT_START_S1 = 0;
  localparam int BIT_DCC_OFF = 0;
  // ==========================================
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_CNT = 4'h0;
  // ==========================================
  // carriers
  typedef struct packed {
    logic [3:0] low;
    logic [3:0] high;
    logic [3:0] phase;
    logic bypass;
    logic start;
  } ccdiv_stage_s;
endpackage

// [ccdiv_top.sv]
// ccdiv_top: two cascaded channel divider stages behind a classic wishbone slave
// What this block does
// RULE1 - stage one low lasts low field plus one
// RULE2 - stage one high lasts high field plus one
// RULE3 - low field zero gives one low cycle
// RULE4 - high field zero gives one high cycle
// RULE5 - stage two has own low/high fields
// RULE6 - four-bit phase offset per stage
// RULE7 - stage two bypass passes input, powers down
// RULE8 - stage one bypass passes input, powers down
// RULE9 - sync-ignore bit clear means obey sync
// RULE10 - force bit sets static output level only with sync-ignore bit set
// RULE11 - stage two start level selectable
// RULE12 - stage one start level selectable
// RULE13 - duty correction on unless disable set
// RULE14 - divider three stage one count fields
// RULE15 - stage one output clocks stage two
// RULE16 - obeyed sync restarts from phase offset
`timescale 1ns/100ps
`default_nettype none
module ccdiv_top (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [9:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic STB_I,
  input wire logic CYC_I,
  output logic ACK_O,
  input wire logic SYNC_REQ,
  output logic CH_CLK_OUT,
  output logic DUTY_CORR_EN,
  output logic [7:0] DIV3_S1_COUNTS
);
  // ==========================================
  // register file and bus slave
  logic [7:0] s1c_reg, s1c_next, ph_reg, ph_next, s2c_reg, s2c_next;
  logic [7:0] ctl_reg, ctl_next, dcc_reg, dcc_next, d3_reg, d3_next;
  logic ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic wr_en;
  logic [7:0] status;
  logic [1:0] out_reg;
  logic sync_lvl_reg;

  always_comb begin
    s1c_next = s1c_reg;
    ph_next = ph_reg;
    s2c_next = s2c_reg;
    ctl_next = ctl_reg;
    dcc_next = dcc_reg;
    d3_next = d3_reg;
    status = {5'h00, sync_lvl_reg, out_reg};
    // answer one cycle after the strobe, drop it the cycle after
    ack_next = CYC_I & STB_I & ~ack_reg;
    wr_en = ack_next & WE_I & SEL_I[0];
    rd_next = 32'h0000_0000;
    case (ADR_I)
      ccdiv_pkg::IDX_S1_COUNTS: rd_next = {24'h000000, s1c_reg};
      ccdiv_pkg::IDX_PHASE: rd_next = {24'h000000, ph_reg};
      ccdiv_pkg::IDX_S2_COUNTS: rd_next = {24'h000000, s2c_reg};
      ccdiv_pkg::IDX_CONTROL: rd_next = {24'h000000, ctl_reg};
      ccdiv_pkg::IDX_DUTY: rd_next = {24'h000000, dcc_reg};
      ccdiv_pkg::IDX_D3_COUNTS: rd_next = {24'h000000, d3_reg};
      ccdiv_pkg::IDX_STATUS: rd_next = {24'h000000, status};
      default: rd_next = 32'h0000_0000;
    endcase
    if (wr_en) begin
      case (ADR_I)
        // RULE1 RULE2 stage one counts
        ccdiv_pkg::IDX_S1_COUNTS: s1c_next = DAT_I[7:0];
        // RULE6 phase offsets
        ccdiv_pkg::IDX_PHASE: ph_next = DAT_I[7:0];
        // RULE5 stage two counts
        ccdiv_pkg::IDX_S2_COUNTS: s2c_next = DAT_I[7:0];
        // unused control bits read back zero
        ccdiv_pkg::IDX_CONTROL: ctl_next = {2'h0, DAT_I[5:0]};
        ccdiv_pkg::IDX_DUTY: dcc_next = {7'h00, DAT_I[0]};
        // RULE14 divider three counts
        ccdiv_pkg::IDX_D3_COUNTS: d3_next = DAT_I[7:0];
        default: ;
      endcase
    end
    if (!ack_next) begin
      rd_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s1c_reg <= ccdiv_pkg::RST_REG;
      ph_reg <= ccdiv_pkg::RST_REG;
      s2c_reg <= ccdiv_pkg::RST_REG;
      ctl_reg <= ccdiv_pkg::RST_REG;
      dcc_reg <= ccdiv_pkg::RST_REG;
      d3_reg <= ccdiv_pkg::RST_REG;
      ack_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
    end else begin
      s1c_reg <= s1c_next;
      ph_reg <= ph_next;
      s2c_reg <= s2c_next;
      ctl_reg <= ctl_next;
      dcc_reg <= dcc_next;
      d3_reg <= d3_next;
      ack_reg <= ack_next;
      rd_reg <= rd_next;
    end
  end

  // ==========================================
  // sync pin and divider input clock
  logic [2:0] sy_reg, sy_next;
  logic sync_lvl_next, clk_in_reg, clk_in_next, restart;

  always_comb begin
    sy_next = {sy_reg[1:0], SYNC_REQ};
    sync_lvl_next = sync_lvl_reg;
    // level changes only once the second and third stages agree
    if (sy_reg[1] == sy_reg[2]) begin
      sync_lvl_next = sy_reg[2];
    end
    // divider input clock modelled at half the reference rate
    clk_in_next = ~clk_in_reg;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sy_reg <= 3'h0;
      sync_lvl_reg <= 1'b0;
      clk_in_reg <= 1'b0;
    end else begin
      sy_reg <= sy_next;
      sync_lvl_reg <= sync_lvl_next;
      clk_in_reg <= clk_in_next;
    end
  end

  // a held sync with the ignore bit clear keeps both stages frozen, so no runt pulse reaches the pin
  // RULE9 obey sync unless ignore bit set
  assign restart = sync_lvl_reg & ~ctl_reg[ccdiv_pkg::BIT_NOSYNC];

  // ==========================================
  // divider stages
  ccdiv_pkg::ccdiv_stage_s cfg [2];
  logic [1:0] in_lvl, in_d_reg;
  logic [3:0] cnt_reg [2];

  assign cfg[0] = '{low: s1c_reg[ccdiv_pkg::LOW_LSB +: 4], high: s1c_reg[ccdiv_pkg::HIGH_LSB +: 4],
    phase: ph_reg[ccdiv_pkg::PH_S1_LSB +: 4], bypass: ctl_reg[ccdiv_pkg::BIT_BYP_S1],
    start: ctl_reg[ccdiv_pkg::BIT_START_S1]};
  assign cfg[1] = '{low: s2c_reg[ccdiv_pkg::LOW_LSB +: 4], high: s2c_reg[ccdiv_pkg::HIGH_LSB +: 4],
    phase: ph_reg[ccdiv_pkg::PH_S2_LSB +: 4], bypass: ctl_reg[ccdiv_pkg::BIT_BYP_S2],
    start: ctl_reg[ccdiv_pkg::BIT_START_S2]};
  // RULE15 stage one output clocks stage two
  assign in_lvl = {out_reg[0], clk_in_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_stage
      logic out_next, in_d_next;
      logic [3:0] cnt_next, lim;
      always_comb begin
        out_next = out_reg[gi];
        cnt_next = cnt_reg[gi];
        in_d_next = in_lvl[gi];
        lim = out_reg[gi] ? cfg[gi].high : cfg[gi].low;
        if (restart) begin
          // RULE16 RULE11 RULE12 restart at phase, start level
          out_next = cfg[gi].start;
          cnt_next = cfg[gi].phase;
        end else if (cfg[gi].bypass) begin
          // RULE7 RULE8 counter parked as power-down
          out_next = in_lvl[gi];
          cnt_next = ccdiv_pkg::RST_CNT;
        end else if (in_lvl[gi] & ~in_d_reg[gi]) begin
          // RULE1 RULE2 RULE3 RULE4 hold for field plus one
          if (cnt_reg[gi] >= lim) begin
            out_next = ~out_reg[gi];
            cnt_next = ccdiv_pkg::RST_CNT;
          end else begin
            cnt_next = cnt_reg[gi] + 4'h1;
          end
        end
      end
      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          out_reg[gi] <= 1'b0;
          cnt_reg[gi] <= ccdiv_pkg::RST_CNT;
          in_d_reg[gi] <= 1'b0;
        end else begin
          out_reg[gi] <= out_next;
          cnt_reg[gi] <= cnt_next;
          in_d_reg[gi] <= in_d_next;
        end
      end
    end
  endgenerate

  // ==========================================
  // outputs
  logic ch_next;
  always_comb begin
    // RULE10 static level while sync held
    if (sync_lvl_reg) begin
      ch_next = ctl_reg[ccdiv_pkg::BIT_FORCE] & ctl_reg[ccdiv_pkg::BIT_NOSYNC];
    end else begin
      ch_next = out_reg[1];
    end
  end

  // registered again so the pin never shows a decode glitch
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      CH_CLK_OUT <= 1'b0;
      DUTY_CORR_EN <= 1'b1;
      DIV3_S1_COUNTS <= ccdiv_pkg::RST_REG;
    end else begin
      CH_CLK_OUT <= ch_next;
      // RULE13 correction on while disable clear
      DUTY_CORR_EN <= ~dcc_reg[ccdiv_pkg::BIT_DCC_OFF];
      DIV3_S1_COUNTS <= d3_reg;
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = rd_reg;

  // ==========================================
  // assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // input-rise helpers mirror the stage edge detectors
  logic run0, run1, rise0, rise1;
  assign run0 = ~restart & ~cfg[0].bypass;
  assign run1 = ~restart & ~cfg[1].bypass;
  assign rise0 = clk_in_reg & ~in_d_reg[0];
  assign rise1 = out_reg[0] & ~in_d_reg[1];

  AST_S1_LOW_HOLD: assert property ( // RULE1
    run0 && rise0 && !out_reg[0] && cnt_reg[0] < cfg[0].low |=> !out_reg[0])
    else $error("stage one left low too early");
  AST_S1_HIGH_HOLD: assert property ( // RULE2
    run0 && rise0 && out_reg[0] && cnt_reg[0] < cfg[0].high |=> out_reg[0])
    else $error("stage one left high too early");
  AST_LOW_ZERO: assert property ( // RULE3
    run0 && rise0 && !out_reg[0] && cfg[0].low == 4'h0 |=> out_reg[0])
    else $error("zero low count not one cycle");
  AST_HIGH_ZERO: assert property ( // RULE4
    run1 && rise1 && out_reg[1] && cfg[1].high == 4'h0 |=> !out_reg[1])
    else $error("zero high count not one cycle");
  AST_S2_LOW_HOLD: assert property ( // RULE5
    run1 && rise1 && !out_reg[1] && cnt_reg[1] < cfg[1].low |=> !out_reg[1])
    else $error("stage two left low too early");
  AST_S2_BYPASS: assert property ( // RULE7
    !restart && cfg[1].bypass |=> out_reg[1] == $past(out_reg[0]) && cnt_reg[1] == 4'h0)
    else $error("stage two bypass wrong");
  AST_S1_BYPASS: assert property ( // RULE8
    !restart && cfg[0].bypass |=> out_reg[0] == $past(clk_in_reg))
    else $error("stage one bypass wrong");
  AST_SYNC_IGNORED: assert property ( // RULE9
    sync_lvl_reg && ctl_reg[ccdiv_pkg::BIT_NOSYNC] && !cfg[0].bypass && rise0
      |=> cnt_reg[0] != $past(cnt_reg[0]) || out_reg[0] != $past(out_reg[0]))
    else $error("sync obeyed while ignored");
  AST_FORCE_LEVEL: assert property ( // RULE10
    sync_lvl_reg |=> CH_CLK_OUT == ($past(ctl_reg[2]) & $past(ctl_reg[3])))
    else $error("forced level wrong");
  AST_DCC: assert property ( // RULE13
    ##1 DUTY_CORR_EN == !$past(dcc_reg[0]))
    else $error("duty correction enable wrong");
  AST_RESTART_PHASE: assert property ( // RULE16
    restart |=> cnt_reg[0] == $past(cfg[0].phase) && out_reg[1] == $past(cfg[1].start))
    else $error("restart did not load phase and start");
  AST_BUS_ACK: assert property (
    CYC_I && STB_I && !ack_reg |=> ACK_O ##1 !ACK_O)
    else $error("bus answer timing wrong");
  // stage two low end, restart loads, register landing and export
  AST_S2_LOW_END: assert property ( // RULE5
    run1 && rise1 && !out_reg[1] && cnt_reg[1] >= cfg[1].low |=> out_reg[1])
    else $error("stage two stayed low too long");
  AST_S1_START: assert property ( // RULE12
    restart |=> out_reg[0] == $past(cfg[0].start))
    else $error("stage one start level wrong");
  AST_S2_PHASE: assert property ( // RULE6
    restart |=> cnt_reg[1] == $past(cfg[1].phase))
    else $error("stage two phase not loaded");
  AST_DIV3: assert property ( // RULE14
    ##1 DIV3_S1_COUNTS == $past(d3_reg))
    else $error("divider three counts not exported");
  AST_S1_WRITE: assert property ( // RULE1
    CYC_I && STB_I && WE_I && SEL_I[0] && !ack_reg && ADR_I == ccdiv_pkg::IDX_S1_COUNTS
      |=> s1c_reg == $past(DAT_I[7:0]))
    else $error("stage one count write lost");

  // main scenarios: toggling, restart, forced level, bypass
  COV_S1_TOGGLE: cover property (run0 ##1 $rose(out_reg[0]) ##[1:40] $fell(out_reg[0]));
  COV_S2_TOGGLE: cover property (run1 && $rose(out_reg[1]));
  COV_SYNC_RESTART: cover property ($fell(restart) ##[1:40] $changed(out_reg[1]));
  COV_FORCE_HIGH: cover property (sync_lvl_reg && CH_CLK_OUT);
  COV_BOTH_BYPASS: cover property (cfg[0].bypass && cfg[1].bypass && $rose(CH_CLK_OUT));
endmodule
`default_nettype wire

// [ccdiv_top_tb.sv]
// ccdiv_top_tb: register and waveform checks of the channel divider
`timescale 1ns/100ps
`default_nettype none
module ccdiv_top_tb;
  // ==========================================
  // stimulus and observation
  logic REF_CLK = 1'b0;
  logic SRST = 1'b1;
  logic [9:0] ADR_I = 10'h000;
  logic [31:0] DAT_I = 32'h0;
  logic WE_I = 1'b0;
  logic [3:0] SEL_I = 4'h0;
  logic STB_I = 1'b0;
  logic CYC_I = 1'b0;
  logic SYNC_REQ = 1'b0;
  logic [31:0] DAT_O;
  logic ACK_O, CH_CLK_OUT, DUTY_CORR_EN;
  logic [7:0] DIV3_S1_COUNTS;
  logic [15:0] hi_len, lo_len;
  logic [31:0] rd;
  int mismatches = 0;
  int n_compared = 0;
  initial forever #50 REF_CLK = ~REF_CLK;
  ccdiv_top DUT (.REF_CLK(REF_CLK), .SRST(SRST), .ADR_I(ADR_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .WE_I(WE_I), .SEL_I(SEL_I), .STB_I(STB_I), .CYC_I(CYC_I),
    .ACK_O(ACK_O), .SYNC_REQ(SYNC_REQ), .CH_CLK_OUT(CH_CLK_OUT),
    .DUTY_CORR_EN(DUTY_CORR_EN), .DIV3_S1_COUNTS(DIV3_S1_COUNTS));
  ccdiv_out_model drv (.clk(REF_CLK), .rst(SRST), .clk_in(CH_CLK_OUT), .hi_len(hi_len),
    .lo_len(lo_len));
  // ==========================================
  // tasks
  task results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // no cycle count assumed, only a bounded wait for ack
  task wb(input logic [9:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int t;
    t = 0;
    @(posedge REF_CLK);
    ADR_I <= a;
    WE_I <= w;
    DAT_I <= d;
    SEL_I <= s;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    do begin
      @(posedge REF_CLK);
      t++;
    end while (ACK_O !== 1'b1 && t < 50);
    if (t >= 50) begin
      mismatches++;
      $display("MISMATCH bus ack expected 1 seen %b", ACK_O);
    end
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask
  task wr(input logic [9:0] a, input logic [31:0] d);
    wb(a, 1'b1, d, 4'h1);
  endtask
  task rchk(input logic [9:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0, 4'hf);
    chk("register", e, rd);
  endtask
  // slowest period plus sync release and phase transient fit twice over
  task meas(input logic [15:0] hi, input logic [15:0] lo);
    repeat (120) @(posedge REF_CLK);
    chk("high run", {16'h0, hi}, {16'h0, hi_len});
    chk("low run", {16'h0, lo}, {16'h0, lo_len});
  endtask
  // ==========================================
  // sequence
  initial begin
    repeat (3) @(posedge REF_CLK);
    SRST <= 1'b0;
    @(posedge REF_CLK);
    chk("duty enable", 32'h1, {31'h0, DUTY_CORR_EN});
    for (int i = 0; i < 6; i++) rchk(10'h199 + 10'(i), 32'h0);
    meas(16'h0004, 16'h0004);
    wr(ccdiv_pkg::IDX_S1_COUNTS, 32'hffffff21);
    rchk(ccdiv_pkg::IDX_S1_COUNTS, 32'h21);
    wr(ccdiv_pkg::IDX_S2_COUNTS, 32'h10);
    meas(16'h000a, 16'h0014);
    wr(ccdiv_pkg::IDX_CONTROL, 32'h20);
    meas(16'h0004, 16'h0006);
    wr(ccdiv_pkg::IDX_CONTROL, 32'h30);
    meas(16'h0001, 16'h0001);
    wb(ccdiv_pkg::IDX_S1_COUNTS, 1'b1, 32'h55, 4'h0);
    rchk(ccdiv_pkg::IDX_S1_COUNTS, 32'h21);
    wr(10'h1a5, 32'h77);
    rchk(10'h1a5, 32'h0);
    wr(ccdiv_pkg::IDX_DUTY, 32'h1);
    // outputs sit one register behind the written one
    repeat (2) @(posedge REF_CLK);
    chk("duty enable", 32'h0, {31'h0, DUTY_CORR_EN});
    wr(ccdiv_pkg::IDX_D3_COUNTS, 32'h3c);
    repeat (2) @(posedge REF_CLK);
    chk("div3 counts", 32'h3c, {24'h0, DIV3_S1_COUNTS});
    wr(ccdiv_pkg::IDX_PHASE, 32'h5a);
    rchk(ccdiv_pkg::IDX_PHASE, 32'h5a);
    // force without nosync must not take the output high
    wr(ccdiv_pkg::IDX_CONTROL, 32'h07);
    SYNC_REQ <= 1'b1;
    repeat (10) @(posedge REF_CLK);
    chk("forced output", 32'h0, {31'h0, CH_CLK_OUT});
    rchk(ccdiv_pkg::IDX_STATUS, 32'h07);
    wr(ccdiv_pkg::IDX_CONTROL, 32'h0c);
    repeat (10) @(posedge REF_CLK);
    chk("forced output", 32'h1, {31'h0, CH_CLK_OUT});
    wr(ccdiv_pkg::IDX_CONTROL, 32'h00);
    SYNC_REQ <= 1'b0;
    meas(16'h000a, 16'h0014);
    results();
  end
  initial begin
    #2000000;
    mismatches++;
    $display("MISMATCH watchdog expected finish seen timeout");
    results();
  end
endmodule
`default_nettype wire
